// *** include/apmc_pkg.sv ***
// apmc_pkg: shared constants and types of the amplifier protection/mode controller.
// assumes a 20 MHz system clock; the analog comparators deliver plain levels.
package apmc_pkg;

  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned RETRY_MS  = 50;
  localparam int unsigned RETRY_CYC = CLK_HZ / 1000 * RETRY_MS;

  // strap code from the mode resistor, 0 = short .. 5 = open
  localparam logic [2:0] STRAP_RST = 3'h0;
  localparam int unsigned STRAP_BD_BIT = 0;
  localparam logic [2:0] STRAP_HALF_LO = 3'h2;
  localparam logic [2:0] STRAP_HALF_HI = 3'h3;
  localparam logic [2:0] STRAP_PAR_LO  = 3'h4;

  // phase offset selection codes
  localparam logic [2:0] PH_QUARTER = 3'h0;
  localparam logic [2:0] PH_THIRD   = 3'h1;
  localparam logic [2:0] PH_HALF    = 3'h2;
  localparam logic [2:0] PH_2THIRD  = 3'h3;
  localparam logic [2:0] PH_3QUART  = 3'h4;

  localparam int unsigned SYNC_W = 17;

  typedef struct packed {
    logic       fold;
    logic       hot;
    logic       deep;
    logic       low;
    logic       high;
    logic       ofs;
    logic [1:0] ilim;
    logic [1:0] sload;
    logic [1:0] srail;
  } apmc_flt_t;

  typedef struct packed {
    logic       inphase;
    logic [2:0] phase_sel;
    logic       fault_flag_pin_mask;
    logic       sd_mask;
  } apmc_cfg_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_WIN, ST_MUTE, ST_OPER, ST_UVMUTE, ST_SHUT, ST_PORWAIT
  } apmc_state_t;

endpackage : apmc_pkg

// *** design/apmc_chan_retry.sv ***
// apmc_chan_retry: per-channel short shutdown with timed retry.
// assumes short inputs are already synchronised to sys_clk.
`timescale 1ns/100ps
module apmc_chan_retry #(
  parameter int unsigned RETRY_CYC = apmc_pkg::RETRY_CYC
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic run,
  input  wire logic short_load,
  input  wire logic short_rail,
  output logic      ch_on,
  output logic      wp_block
);
  localparam int unsigned CW = $clog2(RETRY_CYC + 1);

  logic          off_r;
  logic [CW-1:0] cnt_r;
  wire           expired = (cnt_r == '0);
  wire           short_any = short_load | short_rail;

  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) begin
      off_r <= 1'b0;
      cnt_r <= '0;
    end else if (!off_r && short_any) begin
      off_r <= 1'b1;
      cnt_r <= CW'(RETRY_CYC - 1);
    end else if (off_r && !expired) begin
      cnt_r <= cnt_r - 1'b1;
    end else if (off_r && !short_rail) begin
      off_r <= 1'b0;
    end
  end

  assign ch_on    = run & ~off_r;
  assign wp_block = off_r & expired & short_rail;

  property p_rail_hold;
    @(posedge sys_clk) disable iff (!nrst)
      run && off_r && short_rail |=> off_r || !run;
  endproperty
  a_rail_hold: assert property (p_rail_hold) else $error("restart during rail short");

  property p_off_on_short;
    @(posedge sys_clk) disable iff (!nrst)
      run && ch_on && short_any && $past(run) |=> !ch_on || !run;
  endproperty
  a_off_on_short: assert property (p_off_on_short) else $error("channel kept on in short");

  c_retry: cover property (@(posedge sys_clk) disable iff (!nrst) off_r ##1 !off_r);

endmodule : apmc_chan_retry

// *** design/apmc_ctrl.sv ***
// apmc_ctrl: mode selection and fault-protection sequencing of a
// two-channel switching amplifier.
// assumes comparator levels, power-on, guard and strap pins are asynchronous;
// mode_i2c, mute_req and host_* come from logic on sys_clk.
`timescale 1ns/100ps
module apmc_ctrl #(
  parameter int unsigned RETRY_CYC = apmc_pkg::RETRY_CYC,
  parameter int unsigned NCH       = 2
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   power_on_pin,
  input  wire logic                   offset_guard_pin,
  input  wire logic [2:0]             strap_select_pin,
  input  wire logic                   mode_i2c,
  input  wire logic                   clk_slave,
  input  wire logic                   pll_en,
  input  wire logic                   mute_req,
  input  wire apmc_pkg::apmc_cfg_t    host_cfg,
  input  wire logic                   host_start,
  input  wire logic                   host_alarm_clr,
  input  wire apmc_pkg::apmc_flt_t    flt_in,
  output logic                        inphase_switching,
  output logic                        antiphase_r,
  output logic                        inv_input_r,
  output logic                        phase_offset_en_r,
  output logic [2:0]                  phase_sel_r,
  output logic                        parallel_mode_r,
  output logic                        gain_reduce_r,
  output logic [1:0]                  cur_regulate_r,
  output logic [1:0]                  ch_enable_r,
  output logic                        mute_r,
  output logic                        switching_r,
  output logic                        offset_alarm_flag,
  output logic                        fault_flag_pin_o,
  output logic                        fault_flag_pin_oe
);

  // two-stage synchroniser for every asynchronous level
  logic [apmc_pkg::SYNC_W-1:0] meta_r;
  logic [apmc_pkg::SYNC_W-1:0] sync_r;
  wire  [apmc_pkg::SYNC_W-1:0] raw = {power_on_pin, offset_guard_pin,
                                      strap_select_pin, flt_in};

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  apmc_pkg::apmc_flt_t flt;
  wire       pwr_s;
  wire       guard_s;
  wire [2:0] strap_s;
  assign {pwr_s, guard_s, strap_s, flt} = sync_r;

  // strap decode, used for both the live and latched code
  function automatic logic strap_half(input logic [2:0] c);
    strap_half = (c == apmc_pkg::STRAP_HALF_LO) || (c == apmc_pkg::STRAP_HALF_HI);
  endfunction

  function automatic logic strap_bd(input logic [2:0] c);
    strap_bd = c[apmc_pkg::STRAP_BD_BIT];
  endfunction

  function automatic logic ph_valid(input logic [2:0] c);
    ph_valid = (c <= apmc_pkg::PH_3QUART);
  endfunction

  apmc_pkg::apmc_state_t state_r;
  apmc_pkg::apmc_state_t state_nxt;
  logic       strap_held_r;
  logic [2:0] strap_r;
  logic       dc_latch_r;
  logic [NCH-1:0] ch_on;
  logic [NCH-1:0] wp_block;

  // fault summary; complete shutdown dominates channel actions
  wire rail_any  = |flt.srail;
  wire load_any  = |flt.sload;
  wire guard_on  = guard_s;
  wire por_evt   = mode_i2c & flt.deep;
  wire complete  = flt.hot | flt.high | dc_latch_r;
  wire sw_state  = (state_r == apmc_pkg::ST_MUTE) || (state_r == apmc_pkg::ST_OPER);
  wire ofs_seen  = guard_on & flt.ofs & sw_state;
  wire ofs_sd    = ofs_seen & (~mode_i2c | ~host_cfg.sd_mask);
  // flag stands while the offset shutdown is latched, not just for one cycle
  wire ofs_fault_flag_pin  = (ofs_seen | dc_latch_r) &
                   (~mode_i2c | ~host_cfg.fault_flag_pin_mask);

  always_comb begin
    state_nxt = state_r;
    if (por_evt) begin
      state_nxt = apmc_pkg::ST_PORWAIT;
    end else if (state_r == apmc_pkg::ST_PORWAIT) begin
      if (host_start) begin
        state_nxt = apmc_pkg::ST_WIN;
      end
    end else if (!pwr_s) begin
      state_nxt = apmc_pkg::ST_OFF;
    end else if (complete || ofs_sd) begin
      state_nxt = apmc_pkg::ST_SHUT;
    end else begin
      case (state_r)
        apmc_pkg::ST_OFF: begin
          state_nxt = apmc_pkg::ST_WIN;
        end
        apmc_pkg::ST_WIN: begin
          if (!rail_any && !flt.low) begin
            state_nxt = apmc_pkg::ST_MUTE;
          end
        end
        apmc_pkg::ST_MUTE: begin
          if (flt.low) begin
            state_nxt = apmc_pkg::ST_UVMUTE;
          end else if (!mute_req) begin
            state_nxt = apmc_pkg::ST_OPER;
          end
        end
        apmc_pkg::ST_OPER: begin
          if (flt.low) begin
            state_nxt = apmc_pkg::ST_UVMUTE;
          end else if (mute_req) begin
            state_nxt = apmc_pkg::ST_MUTE;
          end
        end
        apmc_pkg::ST_UVMUTE: begin
          state_nxt = apmc_pkg::ST_SHUT;
        end
        apmc_pkg::ST_SHUT: begin
          if (!flt.low) begin
            state_nxt = apmc_pkg::ST_WIN;
          end
        end
        default: begin
          state_nxt = apmc_pkg::ST_OFF;
        end
      endcase
    end
  end

  wire sw_nxt = (state_nxt == apmc_pkg::ST_MUTE) || (state_nxt == apmc_pkg::ST_OPER) ||
                (state_nxt == apmc_pkg::ST_UVMUTE);
  wire run    = sw_state;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      apmc_chan_retry #(.RETRY_CYC(RETRY_CYC)) u_retry (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .run        (run),
        .short_load (flt.sload[gi]),
        .short_rail (flt.srail[gi]),
        .ch_on      (ch_on[gi]),
        .wp_block   (wp_block[gi])
      );
    end
  endgenerate

  // scheme and phase selection; strap code frozen once switching began
  wire [2:0] strap_use  = strap_held_r ? strap_r : strap_s;
  wire       inph_nxt   = mode_i2c ? host_cfg.inphase : strap_bd(strap_use);
  wire       lock_ok    = clk_slave & pll_en;
  wire       ph_req     = mode_i2c ? ph_valid(host_cfg.phase_sel) : strap_half(strap_use);
  wire [2:0] ph_nxt     = mode_i2c ? host_cfg.phase_sel : apmc_pkg::PH_HALF;
  wire       par_nxt    = mode_i2c & (strap_use >= apmc_pkg::STRAP_PAR_LO);
  wire       flag_nxt   = load_any | rail_any | (|wp_block) | flt.hot | flt.low |
                          flt.high | (state_r == apmc_pkg::ST_PORWAIT) | ofs_fault_flag_pin;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r      <= apmc_pkg::ST_OFF;
      strap_held_r <= 1'b0;
      strap_r      <= apmc_pkg::STRAP_RST;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == apmc_pkg::ST_OFF || state_nxt == apmc_pkg::ST_PORWAIT) begin
        strap_held_r <= 1'b0;
      end else if (!strap_held_r && sw_nxt) begin
        strap_held_r <= 1'b1;
        strap_r      <= strap_s;
      end
    end
  end

  // offset shutdown latch: set wins over the clearing conditions
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dc_latch_r <= 1'b0;
    end else if (ofs_sd) begin
      dc_latch_r <= 1'b1;
    end else if (!pwr_s || !guard_on) begin
      dc_latch_r <= 1'b0;
    end
  end

  // alarm flag: set wins over host clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      offset_alarm_flag <= 1'b0;
    end else if (mode_i2c && ofs_seen) begin
      offset_alarm_flag <= 1'b1;
    end else if (host_alarm_clr) begin
      offset_alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      inphase_switching <= 1'b0;
      antiphase_r       <= 1'b1;
      inv_input_r       <= 1'b0;
      phase_offset_en_r <= 1'b0;
      phase_sel_r       <= apmc_pkg::PH_HALF;
      parallel_mode_r   <= 1'b0;
    end else begin
      inphase_switching <= inph_nxt;
      antiphase_r       <= ~inph_nxt;
      inv_input_r       <= inph_nxt;
      phase_offset_en_r <= lock_ok & ph_req;
      phase_sel_r       <= ph_nxt;
      parallel_mode_r   <= par_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gain_reduce_r     <= 1'b0;
      cur_regulate_r    <= '0;
      ch_enable_r       <= '0;
      mute_r            <= 1'b1;
      switching_r       <= 1'b0;
      fault_flag_pin_o  <= 1'b0;
      fault_flag_pin_oe <= 1'b0;
    end else begin
      gain_reduce_r     <= flt.fold & ~complete;
      cur_regulate_r    <= flt.ilim & {2{sw_nxt}};
      ch_enable_r       <= (state_nxt == apmc_pkg::ST_OPER) ? ch_on : '0;
      mute_r            <= (state_nxt != apmc_pkg::ST_OPER);
      switching_r       <= sw_nxt;
      fault_flag_pin_o  <= 1'b0;
      fault_flag_pin_oe <= flag_nxt;
    end
  end

  property p_anti;
    @(posedge sys_clk) disable iff (!nrst)
      antiphase_r |-> !inphase_switching && !inv_input_r;
  endproperty
  a_anti: assert property (p_anti) else $error("antiphase with inphase set");

  property p_host_scheme;
    @(posedge sys_clk) disable iff (!nrst)
      mode_i2c && host_cfg.inphase |=> inphase_switching && inv_input_r && !antiphase_r;
  endproperty
  a_host_scheme: assert property (p_host_scheme) else $error("host scheme ignored");

  property p_lock_only;
    @(posedge sys_clk) disable iff (!nrst)
      !(clk_slave && pll_en) |=> !phase_offset_en_r;
  endproperty
  a_lock_only: assert property (p_lock_only) else $error("offset without lock");

  property p_strap_half;
    @(posedge sys_clk) disable iff (!nrst)
      !mode_i2c |=> phase_sel_r == apmc_pkg::PH_HALF;
  endproperty
  a_strap_half: assert property (p_strap_half) else $error("strap offset not half");

  property p_hot;
    @(posedge sys_clk) disable iff (!nrst)
      flt.hot && !por_evt |=> !switching_r && ch_enable_r == '0;
  endproperty
  a_hot: assert property (p_hot) else $error("overheat not shut down");

  property p_fold;
    @(posedge sys_clk) disable iff (!nrst)
      flt.fold && !complete |=> gain_reduce_r;
  endproperty
  a_fold: assert property (p_fold) else $error("foldback gain not reduced");

  property p_win;
    @(posedge sys_clk) disable iff (!nrst)
      state_r == apmc_pkg::ST_WIN && rail_any |=> !switching_r;
  endproperty
  a_win: assert property (p_win) else $error("started into rail short");

  property p_dc_hold;
    @(posedge sys_clk) disable iff (!nrst)
      dc_latch_r && pwr_s && guard_on |=> dc_latch_r ##0 !switching_r;
  endproperty
  a_dc_hold: assert property (p_dc_hold) else $error("offset latch lost");

  property p_alarm;
    @(posedge sys_clk) disable iff (!nrst)
      mode_i2c && ofs_seen |=> offset_alarm_flag;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag not set");

  property p_uv;
    @(posedge sys_clk) disable iff (!nrst)
      state_r == apmc_pkg::ST_OPER && flt.low && pwr_s && !complete && !ofs_sd && !por_evt
      |=> mute_r && switching_r;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not muting first");

  property p_por;
    @(posedge sys_clk) disable iff (!nrst)
      state_r == apmc_pkg::ST_PORWAIT && !host_start && !por_evt |=> !switching_r;
  endproperty
  a_por: assert property (p_por) else $error("restart without host");

  property p_flag;
    @(posedge sys_clk) disable iff (!nrst)
      load_any || rail_any |=> fault_flag_pin_oe;
  endproperty
  a_flag: assert property (p_flag) else $error("flag pin not pulled");

  c_strap: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(strap_held_r));
  c_shut: cover property (@(posedge sys_clk) disable iff (!nrst)
    state_r == apmc_pkg::ST_SHUT ##1 state_r == apmc_pkg::ST_WIN);
  c_por: cover property (@(posedge sys_clk) disable iff (!nrst)
    state_r == apmc_pkg::ST_PORWAIT ##1 state_r == apmc_pkg::ST_WIN);

endmodule : apmc_ctrl

// *** test/apmc_board_model.sv ***
// apmc_board_model: strap resistor, guard capacitor and bus host facing the controller.
// assumes the bench sets its requests just after a falling clock edge.
`timescale 1ns/100ps
module apmc_board_model (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic [2:0]          strap_code,
  input  wire logic                cap_fitted,
  input  wire apmc_pkg::apmc_cfg_t cfg_req,
  input  wire logic                start_req,
  output logic [2:0]               strap_select_pin,
  output logic                     offset_guard_pin,
  output apmc_pkg::apmc_cfg_t      host_cfg,
  output logic                     host_start
);
  logic start_q_r;

  assign strap_select_pin = strap_code;
  assign offset_guard_pin = cap_fitted;
  // host sets scheme and offset by command; saturation reports are not modelled
  assign host_cfg = cfg_req;

  // restart command is a single-cycle pulse, whatever the request length
  always_ff @(posedge sys_clk) begin
    start_q_r  <= nrst & start_req;
    host_start <= nrst & start_req & ~start_q_r;
  end
endmodule : apmc_board_model

// *** test/test_apmc_ctrl.sv ***
// test_apmc_ctrl: self-checking bench for the protection and mode controller.
// assumes apmc_pkg and apmc_board_model are compiled first; retry shortened to 20 cycles.
`timescale 1ns/100ps
module test_apmc_ctrl;
  localparam int unsigned RETRY = 20;
  localparam int P_INPH = 16, P_ANTI = 15, P_INV = 14, P_PEN = 13, P_PSEL = 10, P_PAR = 9;
  localparam int P_GAIN = 8, P_CUR = 6, P_CHEN = 4, P_MUTE = 3, P_SW = 2, P_ALM = 1;
  localparam int P_FLG = 0;
  typedef struct {
    int         lo;
    int         w;
    logic [3:0] v;
  } apmc_note_t;
  logic                sys_clk = 1'b0;
  logic                nrst = 1'b0;
  logic                power_on_pin = 1'b0;
  logic                mode_i2c = 1'b0;
  logic                clk_slave = 1'b1;
  logic                pll_en = 1'b1;
  logic                mute_req = 1'b1;
  logic                host_alarm_clr = 1'b0;
  logic                cap_fitted = 1'b1;
  logic                start_req = 1'b0;
  logic [2:0]          strap_code = 3'h0;
  apmc_pkg::apmc_cfg_t cfg_req = '0;
  apmc_pkg::apmc_flt_t flt_in = '0;
  logic [2:0]          strap_select_pin, phase_sel_r;
  logic                offset_guard_pin, host_start;
  apmc_pkg::apmc_cfg_t host_cfg;
  logic                inphase_switching, antiphase_r, inv_input_r, phase_offset_en_r;
  logic                parallel_mode_r, gain_reduce_r, mute_r, switching_r;
  logic                offset_alarm_flag, fault_flag_pin_o, fault_flag_pin_oe;
  logic [1:0]          cur_regulate_r, ch_enable_r;
  logic [16:0]         obs, sh;
  apmc_note_t          q[$];
  apmc_note_t          nt;
  event                noted;
  int                  errors = 0;
  int                  n_compared = 0;
  int                  cycles = 0;
  int                  seed = 32'h4B841FB8;

  assign obs = {inphase_switching, antiphase_r, inv_input_r, phase_offset_en_r, phase_sel_r,
                parallel_mode_r, gain_reduce_r, cur_regulate_r, ch_enable_r, mute_r,
                switching_r, offset_alarm_flag, fault_flag_pin_oe};

  apmc_board_model u_board (.sys_clk, .nrst, .strap_code, .cap_fitted, .cfg_req, .start_req,
    .strap_select_pin, .offset_guard_pin, .host_cfg, .host_start);

  apmc_ctrl #(.RETRY_CYC(RETRY), .NCH(2)) u_dut (
    .sys_clk, .nrst, .power_on_pin, .offset_guard_pin, .strap_select_pin, .mode_i2c,
    .clk_slave, .pll_en, .mute_req, .host_cfg, .host_start, .host_alarm_clr, .flt_in,
    .inphase_switching, .antiphase_r, .inv_input_r, .phase_offset_en_r, .phase_sel_r,
    .parallel_mode_r, .gain_reduce_r, .cur_regulate_r, .ch_enable_r, .mute_r, .switching_r,
    .offset_alarm_flag, .fault_flag_pin_o, .fault_flag_pin_oe);

  always #25 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [3:0] got, input logic [3:0] want);
    n_compared++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, want);
    end
  endtask : check

  task automatic wcyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wcyc

  task automatic exp(input int lo, input int w, input logic [3:0] v);
    q.push_back('{lo, w, v});
    -> noted;
  endtask : exp

  task automatic fin(input string s);
    wcyc(2);
    $display("test %s done", s);
  endtask : fin

  // async pins need two sync flops plus the state walk, hence the margins
  task automatic up();
    power_on_pin = 1'b1;
    wcyc(8);
  endtask : up

  task automatic down();
    power_on_pin = 1'b0;
    wcyc(6);
  endtask : down

  task automatic short_case(input int ch, input bit rail);
    logic seen;
    seen = 1'b0;
    if (rail) flt_in.srail[ch] = 1'b1;
    else flt_in.sload[ch] = 1'b1;
    wcyc(6);
    exp(P_CHEN + ch, 1, 0);
    exp(P_CHEN + 1 - ch, 1, 1);
    exp(P_FLG, 1, 1);
    check(fault_flag_pin_o, 4'h0);
    repeat (RETRY + 10) begin
      wcyc(1);
      if (ch_enable_r[ch] === 1'b1) seen = 1'b1;
    end
    check(seen, !rail);
    flt_in.srail[ch] = 1'b0;
    flt_in.sload[ch] = 1'b0;
    wcyc(RETRY + 10);
    exp(P_CHEN, 2, 3);
  endtask : short_case

  // notes are compared in the step they are made; outputs only move on posedge
  always @(noted) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      sh = obs >> nt.lo;
      check(sh[3:0] & ((4'h1 << nt.w) - 4'h1), nt.v);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    wcyc(3);
    nrst = 1'b1;
    wcyc(2);
    exp(P_ANTI, 1, 1);
    exp(P_MUTE, 1, 1);
    exp(P_PSEL, 3, 2);
    exp(P_SW, 1, 0);
    fin("reset");
    for (int c = 0; c < 6; c++) begin
      strap_code = 3'(c);
      wcyc(4);
      up();
      exp(P_SW, 1, 1);
      exp(P_INPH, 1, 4'(c % 2));
      exp(P_ANTI, 1, 4'(1 - c % 2));
      exp(P_INV, 1, 4'(c % 2));
      exp(P_PEN, 1, 4'(c == 2 || c == 3));
      if (c == 2) exp(P_PSEL, 3, 2);
      clk_slave = (c != 3);
      pll_en = (c != 2);
      wcyc(2);
      exp(P_PEN, 1, 0);
      clk_slave = 1'b1;
      pll_en = 1'b1;
      strap_code = 3'((c + 1 + ($random(seed) & 3)) % 6);
      wcyc(6);
      exp(P_INPH, 1, 4'(c % 2));
      mute_req = 1'b0;
      wcyc(3);
      exp(P_MUTE, 1, 0);
      exp(P_CHEN, 2, 3);
      mute_req = 1'b1;
      down();
    end
    fin("strap schemes");
    mode_i2c = 1'b1;
    strap_code = 3'h0;
    for (int p = 0; p < 6; p++) begin
      cfg_req.phase_sel = 3'(p);
      cfg_req.inphase = 1'($random(seed));
      up();
      exp(P_INPH, 1, {3'h0, cfg_req.inphase});
      exp(P_INV, 1, {3'h0, cfg_req.inphase});
      exp(P_PEN, 1, 4'(p < 5));
      if (p < 5) exp(P_PSEL, 3, 4'(p));
      down();
    end
    strap_code = 3'h4;
    up();
    exp(P_PAR, 1, 1);
    down();
    strap_code = 3'h0;
    fin("bus schemes");
    mute_req = 1'b0;
    up();
    flt_in.deep = 1'b1;
    wcyc(6);
    flt_in.deep = 1'b0;
    wcyc(10);
    exp(P_SW, 1, 0);
    exp(P_FLG, 1, 1);
    start_req = 1'b1;
    wcyc(10);
    start_req = 1'b0;
    exp(P_MUTE, 1, 0);
    cfg_req.fault_flag_pin_mask = 1'b1;
    cfg_req.sd_mask = 1'b1;
    flt_in.ofs = 1'b1;
    wcyc(6);
    flt_in.ofs = 1'b0;
    exp(P_ALM, 1, 1);
    exp(P_FLG, 1, 0);
    exp(P_SW, 1, 1);
    wcyc(6);
    exp(P_ALM, 1, 1);
    host_alarm_clr = 1'b1;
    wcyc(1);
    host_alarm_clr = 1'b0;
    wcyc(2);
    exp(P_ALM, 1, 0);
    cfg_req.fault_flag_pin_mask = 1'b0;
    cfg_req.sd_mask = 1'b0;
    flt_in.ofs = 1'b1;
    wcyc(6);
    flt_in.ofs = 1'b0;
    exp(P_FLG, 1, 1);
    wcyc(10);
    exp(P_SW, 1, 0);
    down();
    up();
    exp(P_SW, 1, 1);
    down();
    fin("bus faults");
    mode_i2c = 1'b0;
    up();
    flt_in.ofs = 1'b1;
    wcyc(6);
    flt_in.ofs = 1'b0;
    exp(P_FLG, 1, 1);
    wcyc(10);
    exp(P_SW, 1, 0);
    cap_fitted = 1'b0;
    wcyc(10);
    exp(P_SW, 1, 1);
    flt_in.ofs = 1'b1;
    wcyc(8);
    exp(P_SW, 1, 1);
    flt_in.ofs = 1'b0;
    cap_fitted = 1'b1;
    mute_req = 1'b1;
    wcyc(6);
    flt_in.ofs = 1'b1;
    wcyc(6);
    flt_in.ofs = 1'b0;
    exp(P_SW, 1, 0);
    cap_fitted = 1'b0;
    wcyc(6);
    cap_fitted = 1'b1;
    mute_req = 1'b0;
    wcyc(12);
    fin("offset guard");
    flt_in.fold = 1'b1;
    flt_in.ilim = 2'h2;
    wcyc(6);
    exp(P_GAIN, 1, 1);
    exp(P_CUR, 2, 2);
    exp(P_CHEN, 2, 3);
    flt_in.ilim = 2'h0;
    for (int k = 0; k < 3; k++) begin
      flt_in.hot = (k == 0);
      flt_in.high = (k == 1);
      flt_in.low = (k == 2);
      if (k == 2) begin
        repeat (8) begin
          @(posedge sys_clk);
          #1;
          if (mute_r === 1'b1) break;
        end
        exp(P_MUTE, 1, 1);
        exp(P_SW, 1, 1);
      end
      wcyc(8);
      exp(P_SW, 1, 0);
      exp(P_CHEN, 2, 0);
      flt_in.hot = 1'b0;
      flt_in.high = 1'b0;
      flt_in.low = 1'b0;
      wcyc(12);
      exp(P_MUTE, 1, 0);
    end
    flt_in.fold = 1'b0;
    fin("thermal and supply");
    short_case(1, 1'b0);
    short_case(0, 1'b1);
    down();
    flt_in.srail = 2'h1;
    up();
    wcyc(10);
    exp(P_SW, 1, 0);
    flt_in.srail = 2'h0;
    wcyc(10);
    exp(P_SW, 1, 1);
    fin("shorts");
    tally_and_finish();
  end
endmodule : test_apmc_ctrl
